// file: fbdac_top.sv
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps

// What this block does
// - Control bit 7 set to one turns the converter on and zero turns it off.
// - Level bits 4 to 0 pick one of 32 steps, output = negative + span times code over 32.
// - Control bits 3:2 choose the positive source: supply, external reference, fixed buffer.
// - Control bit 0 chooses the negative source: one is external reference, zero is ground.
// - Control bit 5 routes the voltage to pin a and bit 4 to pin b, clear bits disconnect.
// - The voltage is never routed to more than one output pin at a time.
// - A routed pin has its digital buffer, input detector, pull-up and current drive off.
// - A digital read of a routed pin gives zero from one clock after its routing bit is set.
// - The converter keeps running in sleep and wake-up leaves the control register alone.
// - Reset turns the converter off, frees all pins and clears the level code.
// - Control sits at index 0x90e, level at 0x90f, and control bits reset to zero.
module fbdac_top
  import fbdac_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [FBDAC_ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sleep_i,
  input wire logic pin_a_raw_i,
  input wire logic pin_b_raw_i,
  output logic dac_enable_o,
  output logic [4:0] level_code_o,
  output logic [1:0] positive_source_select_o,
  output logic negative_source_select_o,
  output logic analog_out_pin_a_o,
  output logic analog_out_pin_b_o,
  output logic pin_a_digital_override_o,
  output logic pin_b_digital_override_o,
  output logic pin_a_read_o,
  output logic pin_b_read_o
);

  logic [7:0] dac_control;
  logic [7:0] next_dac_control;
  logic [4:0] level_code;
  logic [4:0] next_level_code;
  logic ack;
  logic next_ack;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [1:0] pin_meta;
  logic [1:0] pin_sync;
  logic [1:0] next_read;
  logic [1:0] pin_read;
  logic req;
  logic hit_ctrl;
  logic hit_level;
  logic wr_ctrl;
  logic wr_level;
  logic rd_req;
  fbdac_pos_type pos_source;
  fbdac_neg_type neg_source;

  function automatic logic fbdac_hit(input logic [FBDAC_ADDR_W-1:0] a,
                                     input logic [FBDAC_ADDR_W-1:0] b);
    fbdac_hit = (a[FBDAC_ADDR_W-1:2] == b[FBDAC_ADDR_W-1:2]);
  endfunction

  function automatic logic fbdac_pin_level(input logic level, input logic routed);
    fbdac_pin_level = level && !routed;
  endfunction

  assign req = wb_cyc_i && wb_stb_i && !ack;
  assign hit_ctrl = fbdac_hit(wb_adr_i, FBDAC_CONTROL_ADDR);
  assign hit_level = fbdac_hit(wb_adr_i, FBDAC_LEVEL_ADDR);
  assign wr_ctrl = req && wb_we_i && wb_sel_i[0] && hit_ctrl;
  assign wr_level = req && wb_we_i && wb_sel_i[0] && hit_level;
  assign rd_req = req && !wb_we_i;

  // Register writes, read data and acknowledge; sleep has no effect here.
  always_comb begin
    next_dac_control = dac_control;
    next_level_code = level_code;
    next_ack = req;
    next_rdata = rdata;
    if (req && wb_we_i && wb_sel_i[0]) begin
      if (hit_ctrl) begin
        next_dac_control = wb_dat_i[7:0] & FBDAC_CONTROL_MASK;
        if (wb_dat_i[FBDAC_OE_A_BIT] && wb_dat_i[FBDAC_OE_B_BIT]) begin
          // Both set at once: pin a wins, keeping the routing one-hot.
          next_dac_control[FBDAC_OE_B_BIT] = 1'b0;
        end
      end
      if (hit_level) begin
        next_level_code = wb_dat_i[FBDAC_LEVEL_W-1:0];
      end
    end
    if (req && !wb_we_i) begin
      next_rdata = 32'h0000_0000;
      if (hit_ctrl) begin
        next_rdata[7:0] = dac_control;
      end else if (hit_level) begin
        next_rdata[7:0] = {3'b000, level_code};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dac_control <= FBDAC_CONTROL_RESET;
      level_code <= FBDAC_LEVEL_RESET;
      ack <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      dac_control <= next_dac_control;
      level_code <= next_level_code;
      ack <= next_ack;
      rdata <= next_rdata;
    end
  end

  // Pin levels come from outside and pass two flip-flops first.
  always_comb begin
    next_read[0] = fbdac_pin_level(pin_sync[0], dac_control[FBDAC_OE_A_BIT]);
    next_read[1] = fbdac_pin_level(pin_sync[1], dac_control[FBDAC_OE_B_BIT]);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta <= 2'b00;
      pin_sync <= 2'b00;
      pin_read <= 2'b00;
    end else begin
      pin_meta <= {pin_b_raw_i, pin_a_raw_i};
      pin_sync <= pin_meta;
      pin_read <= next_read;
    end
  end

  assign wb_ack_o = ack;
  assign wb_dat_o = rdata;
  assign dac_enable_o = dac_control[FBDAC_EN_BIT];
  assign level_code_o = level_code;
  assign pos_source = fbdac_pos_type'(dac_control[FBDAC_POS_SEL_HI:FBDAC_POS_SEL_LO]);
  assign neg_source = fbdac_neg_type'(dac_control[FBDAC_NEG_SEL_BIT]);
  assign positive_source_select_o = pos_source;
  assign negative_source_select_o = neg_source;
  assign analog_out_pin_a_o = dac_control[FBDAC_OE_A_BIT];
  assign analog_out_pin_b_o = dac_control[FBDAC_OE_B_BIT];
  assign pin_a_digital_override_o = dac_control[FBDAC_OE_A_BIT];
  assign pin_b_digital_override_o = dac_control[FBDAC_OE_B_BIT];
  assign pin_a_read_o = pin_read[0];
  assign pin_b_read_o = pin_read[1];

  one_hot_pins_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(analog_out_pin_a_o && analog_out_pin_b_o))
    else $error("Converter voltage routed to both pins.");

  reset_clears_a: assert property (@(posedge clk_i)
    rst_i |=> (!dac_enable_o && !analog_out_pin_a_o && !analog_out_pin_b_o
                      && level_code_o == 5'h00))
    else $error("Reset left the converter active.");

  routed_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(analog_out_pin_a_o) |-> !pin_a_read_o)
    else $error("Routed pin a read back nonzero.");

  enable_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && wb_we_i && wb_sel_i[0] && hit_ctrl) |=> (dac_enable_o == $past(wb_dat_i[7])))
    else $error("Enable bit did not follow the write.");

  level_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && wb_we_i && wb_sel_i[0] && hit_level) |=> (level_code_o == $past(wb_dat_i[4:0])))
    else $error("Level code did not follow the write.");

  sleep_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (sleep_i && !req) |=> $stable(dac_control))
    else $error("Control changed without a write.");

  ctrl_reserved_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (dac_control & ~FBDAC_CONTROL_MASK) == 8'h00)
    else $error("Unimplemented control bit set.");

  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req) |=> (wb_ack_o ##1 !wb_ack_o))
    else $error("Bus answer not a single cycle.");

  pos_source_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && wb_we_i && wb_sel_i[0] && hit_ctrl) |=>
      (positive_source_select_o == $past(wb_dat_i[3:2])))
    else $error("Positive source select did not follow the write.");

  neg_source_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ctrl |=> (negative_source_select_o == $past(wb_dat_i[0])))
    else $error("Negative source select did not follow the write.");

  enable_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_ctrl && wb_dat_i[7]) |=> dac_enable_o)
    else $error("Converter not enabled by the write.");

  enable_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_ctrl && !wb_dat_i[7]) |=> !dac_enable_o)
    else $error("Converter not disabled by the write.");

  pin_a_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ctrl |=> (analog_out_pin_a_o == $past(wb_dat_i[5])))
    else $error("Pin a routing did not follow the write.");

  pin_b_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ctrl |=> (analog_out_pin_b_o == $past(wb_dat_i[4] && !wb_dat_i[5])))
    else $error("Pin b routing did not follow the write.");

  both_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_ctrl && wb_dat_i[5] && wb_dat_i[4]) |=> (analog_out_pin_a_o && !analog_out_pin_b_o))
    else $error("Both routing bits written but pin a did not win.");

  one_hot_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_req && hit_ctrl) |=> !(wb_dat_o[5] && wb_dat_o[4]))
    else $error("Control read back shows both pins routed.");

  pin_override_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pin_a_digital_override_o == analog_out_pin_a_o)
      && (pin_b_digital_override_o == analog_out_pin_b_o))
    else $error("Digital pin functions not overridden while routed.");

  routed_read_b_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(analog_out_pin_b_o) |-> !pin_b_read_o)
    else $error("Routed pin b read back nonzero.");

  pin_a_pass_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!$past(rst_i) && !$past(rst_i, 2) && !$past(rst_i, 3)) |->
      (pin_a_read_o == ($past(pin_a_raw_i, 3) && !$past(analog_out_pin_a_o))))
    else $error("Pin a read did not follow the pin.");

  pin_b_pass_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!$past(rst_i) && !$past(rst_i, 2) && !$past(rst_i, 3)) |->
      (pin_b_read_o == ($past(pin_b_raw_i, 3) && !$past(analog_out_pin_b_o))))
    else $error("Pin b read did not follow the pin.");

  sleep_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (sleep_i && !wr_level) |=> $stable(level_code_o))
    else $error("Level code changed during sleep without a write.");

  sleep_pins_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (sleep_i && !wr_ctrl) |=> ($stable(analog_out_pin_a_o) && $stable(analog_out_pin_b_o)
      && $stable(dac_enable_o)))
    else $error("Converter outputs changed during sleep without a write.");

  ctrl_change_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !wr_ctrl |=> $stable(dac_control))
    else $error("Control register changed without a write.");

  level_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !wr_level |=> $stable(level_code_o))
    else $error("Level code changed without a write.");

  ctrl_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_req && hit_ctrl) |=> (wb_dat_o == {24'h00_0000, $past(dac_control)}))
    else $error("Control read data wrong.");

  level_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_req && hit_level) |=> (wb_dat_o == {27'h000_0000, $past(level_code_o)}))
    else $error("Level read data wrong.");

  unmapped_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_req && !hit_ctrl && !hit_level) |=> (wb_dat_o == 32'h0000_0000))
    else $error("Unmapped read returned nonzero data.");

  unmapped_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && wb_we_i && !hit_ctrl && !hit_level) |=>
      ($stable(dac_control) && $stable(level_code_o)))
    else $error("Unmapped write changed a register.");

  lane_ignore_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && wb_we_i && !wb_sel_i[0]) |=> ($stable(dac_control) && $stable(level_code_o)))
    else $error("Write without byte lane zero changed a register.");

  read_upper_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> (wb_dat_o[31:8] == 24'h00_0000))
    else $error("Read data upper bits nonzero.");

  read_no_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_req |=> ($stable(dac_control) && $stable(level_code_o)))
    else $error("Read changed a register.");

  ack_taken_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> $past(req))
    else $error("Bus answer without a request.");

  ack_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !req |=> !wb_ack_o)
    else $error("Bus answer raised while idle.");

  ack_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(wb_ack_o) |=> !wb_ack_o)
    else $error("Bus answer longer than one cycle.");

  rdata_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !rd_req |=> $stable(wb_dat_o))
    else $error("Read data changed without a read.");

  bus_reset_a: assert property (@(posedge clk_i)
    rst_i |=> (!wb_ack_o && wb_dat_o == 32'h0000_0000 && !pin_a_read_o && !pin_b_read_o))
    else $error("Reset left the bus or pin reads active.");

endmodule

// file: fbdac_pkg.sv
package fbdac_pkg;

  // Register offsets are word indices; the bus byte address is four times the index.
  localparam logic [11:0] FBDAC_CONTROL_IDX = 12'h90e;
  localparam logic [11:0] FBDAC_LEVEL_IDX = 12'h90f;
  localparam int FBDAC_ADDR_W = 14;
  localparam logic [13:0] FBDAC_CONTROL_ADDR = {FBDAC_CONTROL_IDX, 2'b00};
  localparam logic [13:0] FBDAC_LEVEL_ADDR = {FBDAC_LEVEL_IDX, 2'b00};

  // Control register field positions.
  localparam int FBDAC_EN_BIT = 7;
  localparam int FBDAC_OE_A_BIT = 5;
  localparam int FBDAC_OE_B_BIT = 4;
  localparam int FBDAC_POS_SEL_HI = 3;
  localparam int FBDAC_POS_SEL_LO = 2;
  localparam int FBDAC_NEG_SEL_BIT = 0;
  localparam logic [7:0] FBDAC_CONTROL_MASK = 8'hbd;
  localparam logic [7:0] FBDAC_LEVEL_MASK = 8'h1f;
  localparam logic [7:0] FBDAC_CONTROL_RESET = 8'h00;
  localparam logic [4:0] FBDAC_LEVEL_RESET = 5'h00;
  localparam int FBDAC_LEVEL_W = 5;
  localparam int FBDAC_LEVELS = 32;

  typedef enum logic [1:0] {
    FBDAC_POS_SUPPLY = 2'b00,
    FBDAC_POS_EXT_REF = 2'b01,
    FBDAC_POS_FIXED_REF = 2'b10,
    FBDAC_POS_RESERVED = 2'b11
  } fbdac_pos_type;

  typedef enum logic [0:0] {
    FBDAC_NEG_GROUND = 1'b0,
    FBDAC_NEG_EXT_REF = 1'b1
  } fbdac_neg_type;

endpackage

// file: tb.sv
`timescale 1ns/1ps
module tb;
  import fbdac_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, slp = 0, pa = 0, pb = 0;
  logic [13:0] adr = '0;
  logic [31:0] dat = '0, rd, dat_o, seed = 32'd97;
  logic [3:0] sel = 4'h1;
  logic ack, en, nsel, oa, ob, ova, ovb, ra, rb;
  logic [4:0] lvl;
  logic [1:0] psel;
  logic [7:0] m_ctl = 0, m_lvl = 0;
  int n_errors = 0, checks_done = 0, n_cyc = 0;
  always #2.5 clk_i = ~clk_i;
  fbdac_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .sleep_i(slp), .pin_a_raw_i(pa), .pin_b_raw_i(pb),
    .dac_enable_o(en), .level_code_o(lvl), .positive_source_select_o(psel),
    .negative_source_select_o(nsel), .analog_out_pin_a_o(oa), .analog_out_pin_b_o(ob),
    .pin_a_digital_override_o(ova), .pin_b_digital_override_o(ovb),
    .pin_a_read_o(ra), .pin_b_read_o(rb));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [13:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 0;
    stb <= 0;
  endtask
  task automatic outs();
    chk({en, oa, ob, psel, nsel}, {m_ctl[7], m_ctl[5:2], m_ctl[0]});
    chk({ova, ovb}, m_ctl[5:4]);
    chk(oa & ob, 0);
    chk(lvl, m_lvl[4:0]);
  endtask
  task automatic wr(input logic [13:0] a, input logic [7:0] d, input logic [3:0] s);
    bus(1, a, {24'h0, d}, s);
    if (s[0] && a == FBDAC_CONTROL_ADDR) m_ctl = d & FBDAC_CONTROL_MASK;
    if (s[0] && a == FBDAC_LEVEL_ADDR) m_lvl = d & FBDAC_LEVEL_MASK;
    if (m_ctl[5]) m_ctl[4] = 1'b0;
    bus(0, FBDAC_CONTROL_ADDR, 0, 4'h1);
    chk(rd, m_ctl);
    bus(0, FBDAC_LEVEL_ADDR, 0, 4'h1);
    chk(rd, m_lvl);
    outs();
  endtask
  task automatic final_report();
    $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk_i) begin
    n_cyc++;
    if (n_cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic do_reset();
    rst_i <= 1;
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    m_ctl = 0;
    m_lvl = 0;
  endtask
  initial begin
    logic [31:0] r;
    do_reset();
    wr(14'h0, 8'h00, 4'h0);
    $display("test reset values done");
    for (int i = 0; i < 4; i++) wr(FBDAC_CONTROL_ADDR, 8'h81 | 8'(i << 2), 4'h1);
    wr(FBDAC_CONTROL_ADDR, 8'hff, 4'h1);
    for (int i = 0; i < 40; i++) begin
      r = xs();
      wr(r[0] ? FBDAC_CONTROL_ADDR : FBDAC_LEVEL_ADDR, r[15:8], r[19:16]);
    end
    bus(0, 14'h0010, 0, 4'h1);
    chk(rd, 0);
    wr(14'h0010, 8'hff, 4'h1);
    $display("test register access done");
    for (int i = 0; i < 8; i++) begin
      r = xs();
      wr(FBDAC_CONTROL_ADDR, {2'b10, r[1:0], 4'h0}, 4'h1);
      @(posedge clk_i);
      pa <= r[2];
      pb <= r[3];
      repeat (4) @(posedge clk_i);
      chk({ra, rb}, {r[2] & ~m_ctl[5], r[3] & ~m_ctl[4]});
    end
    $display("test pin reads done");
    @(posedge clk_i);
    slp <= 1;
    repeat (10) @(posedge clk_i);
    outs();
    slp <= 0;
    $display("test sleep done");
    do_reset();
    wr(14'h0, 8'h00, 4'h0);
    $display("test second reset done");
    final_report();
  end
endmodule
